/* File: hw/gjdw_pkg.sv */
package gjdw_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Register bus shape.
  localparam int REG_W = 8;
  localparam int ADDR_W = 16;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [REG_W-1:0] wdata;
    logic wr;
    logic rd;
  } gjdw_bus_t;

  //////////////////////////////////////////////////////////////////////////////
  // Register offsets.
  localparam logic [ADDR_W-1:0] OFF_DATA = 16'h0300;
  localparam logic [ADDR_W-1:0] OFF_DIR = 16'h0301;
  localparam logic [ADDR_W-1:0] OFF_MASK = 16'h0302;
  localparam logic [ADDR_W-1:0] OFF_STAT = 16'h0303;
  localparam logic [ADDR_W-1:0] OFF_PEND = 16'h0304;
  localparam logic [ADDR_W-1:0] OFF_WAKE = 16'h0305;
  localparam logic [ADDR_W-1:0] OFF_SWWAKE = 16'h0306;
  localparam logic [ADDR_W-1:0] OFF_DEB = 16'h0307;

  //////////////////////////////////////////////////////////////////////////////
  // Field layouts and reset values.
  localparam int SEL_W = 3;
  localparam int MAX_PINS = 8;

  typedef struct packed {
    logic [SEL_W-1:0] sel;
    logic hw_en;
  } gjdw_wake_cfg_t;

  localparam int SWWAKE_BIT = 0;
  localparam int DEB_SHORT_BIT = 0;
  localparam logic [REG_W-1:0] RST_DATA = 8'h00;
  localparam logic [REG_W-1:0] RST_DIR = 8'h00;
  localparam logic [REG_W-1:0] RST_MASK = 8'h00;
  localparam gjdw_wake_cfg_t RST_WAKE = '0;

  //////////////////////////////////////////////////////////////////////////////
  // Timing.
  localparam int CLK_KHZ = 250000;
  localparam int DEB_LONG_MS = 16;
  localparam int DEB_SHORT_MS = 8;
  localparam int DEB_LONG_CYC = DEB_LONG_MS * CLK_KHZ;
  localparam int DEB_SHORT_CYC = DEB_SHORT_MS * CLK_KHZ;

endpackage

/* File: hw/gjdw_debounce.sv */
`timescale 1ns/1ns
module gjdw_debounce #(
  parameter int CW = 22
) (
  input wire logic clk_sys, // System clock.
  input wire logic sys_rst, // Synchronous reset, active high.
  input wire logic raw, // Sampled pin level.
  input wire logic [CW-1:0] limit, // Cycles the new level must hold.
  output logic level_q // Filtered level.
);
  import gjdw_pkg::*;

  logic [CW-1:0] cnt_q;

  // A level is accepted only after it has differed for limit cycles in a row.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cnt_q <= '0;
      level_q <= '0;
    end else if (raw == level_q) begin
      cnt_q <= '0;
    end else if (cnt_q >= limit - CW'(1)) begin
      cnt_q <= '0;
      level_q <= raw;
    end else begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

  property p_deb_follow;
    @(posedge clk_sys) disable iff (sys_rst)
      $changed(level_q) |-> ($past(raw) == level_q) && ($past(cnt_q) >= $past(limit) - CW'(1));
  endproperty
  a_deb_follow: assert property (p_deb_follow) else $error("filtered level moved early");

endmodule

/* File: hw/gjdw_gpio.sv */
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ns
module gjdw_gpio #(
  parameter int NPINS = 8,
  parameter int DEB_LONG_CYC = gjdw_pkg::DEB_LONG_CYC,
  parameter int DEB_SHORT_CYC = gjdw_pkg::DEB_SHORT_CYC,
  parameter bit WAKE_CAPABLE = 1'b1
) (
  input wire logic clk_sys, // System clock, 250 MHz.
  input wire logic sys_rst, // Synchronous reset, active high.
  input wire gjdw_pkg::gjdw_bus_t reg_req, // Register request.
  output logic [gjdw_pkg::REG_W-1:0] reg_rdata, // Read data, cycle after read.
  input wire logic [NPINS-1:0] gpio_in, // Pad levels.
  output logic [NPINS-1:0] gpio_out, // Pad output values.
  output logic [NPINS-1:0] gpio_oe_n, // Pad drive enables, low drives.
  input wire logic usb_suspended, // Link is in suspend.
  input wire logic host_wake_en, // Host enabled remote wakeup.
  output logic remote_wake, // One-cycle wakeup request pulse.
  output logic wake_capable, // Capability flag for the descriptor.
  output logic irq // Level interrupt to the controller.
);
  import gjdw_pkg::*;

  localparam int CW = $clog2(DEB_LONG_CYC + 1);

  //////////////////////////////////////////////////////////////////////////////
  // Parameter checks.

  if (NPINS < 1 || NPINS > MAX_PINS) begin : g_bad_pins
    $error("NPINS must lie between 1 and 8");
  end
  if (DEB_SHORT_CYC < 1 || DEB_SHORT_CYC > DEB_LONG_CYC) begin : g_bad_deb
    $error("debounce counts must satisfy 1 <= short <= long");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Decode.

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  logic wr_data, wr_dir, wr_mask, wr_stat, wr_wake, wr_sw, wr_deb;
  logic rd_data;

  assign wr_data = reg_req.wr && hit(reg_req.addr, OFF_DATA);
  assign wr_dir = reg_req.wr && hit(reg_req.addr, OFF_DIR);
  assign wr_mask = reg_req.wr && hit(reg_req.addr, OFF_MASK);
  assign wr_stat = reg_req.wr && hit(reg_req.addr, OFF_STAT);
  assign wr_wake = reg_req.wr && hit(reg_req.addr, OFF_WAKE);
  assign wr_sw = reg_req.wr && hit(reg_req.addr, OFF_SWWAKE);
  assign wr_deb = reg_req.wr && hit(reg_req.addr, OFF_DEB);
  assign rd_data = reg_req.rd && hit(reg_req.addr, OFF_DATA);

  //////////////////////////////////////////////////////////////////////////////
  // Registers written by software.

  logic [NPINS-1:0] data_q;
  logic [NPINS-1:0] dir_q;
  logic [NPINS-1:0] mask_q;
  gjdw_wake_cfg_t wake_q;
  logic sw_wake_q;
  logic deb_short_q;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      data_q <= RST_DATA[NPINS-1:0];
    end else if (wr_data) begin
      data_q <= reg_req.wdata[NPINS-1:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      dir_q <= RST_DIR[NPINS-1:0];
    end else if (wr_dir) begin
      dir_q <= reg_req.wdata[NPINS-1:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      mask_q <= RST_MASK[NPINS-1:0];
    end else if (wr_mask) begin
      mask_q <= reg_req.wdata[NPINS-1:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wake_q <= RST_WAKE;
      sw_wake_q <= '0;
      deb_short_q <= '0;
    end else begin
      if (wr_wake) begin
        wake_q <= gjdw_wake_cfg_t'(reg_req.wdata[$bits(gjdw_wake_cfg_t)-1:0]);
      end
      if (wr_sw) begin
        sw_wake_q <= reg_req.wdata[SWWAKE_BIT];
      end
      if (wr_deb) begin
        deb_short_q <= reg_req.wdata[DEB_SHORT_BIT];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pads.

  logic [NPINS-1:0] out_q;
  logic [NPINS-1:0] oe_n_q;
  logic [NPINS-1:0] pin_q;

  // Pins come up as inputs so nothing fights an external driver after reset.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      out_q <= RST_DATA[NPINS-1:0];
      oe_n_q <= '1;
    end else begin
      out_q <= data_q;
      oe_n_q <= ~dir_q;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pin_q <= '0;
    end else begin
      pin_q <= gpio_in;
    end
  end

  assign gpio_out = out_q;
  assign gpio_oe_n = oe_n_q;

  //////////////////////////////////////////////////////////////////////////////
  // Change detection with debounce.

  logic [CW-1:0] deb_limit;
  logic [NPINS-1:0] deb_lvl;
  logic [NPINS-1:0] deb_prev_q;
  logic [NPINS-1:0] chg;

  assign deb_limit = deb_short_q ? CW'(DEB_SHORT_CYC) : CW'(DEB_LONG_CYC);

  for (genvar i = 0; i < NPINS; i++) begin : g_deb
    gjdw_debounce #(.CW(CW)) u_deb (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .raw(pin_q[i]),
      .limit(deb_limit),
      .level_q(deb_lvl[i])
    );
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      deb_prev_q <= '0;
    end else begin
      deb_prev_q <= deb_lvl;
    end
  end

  // Output pins echo their own drive on the pad, so only inputs report changes.
  assign chg = (deb_lvl ^ deb_prev_q) & ~dir_q;

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt status, pending changes and the interrupt line.

  logic [NPINS-1:0] stat_q;
  logic [NPINS-1:0] pend_q;
  logic irq_q;

  // A change in the same cycle as a clear wins, so no edge is dropped.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      stat_q <= '0;
    end else begin
      stat_q <= (stat_q & ~(wr_stat ? reg_req.wdata[NPINS-1:0] : '0)) | chg;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pend_q <= '0;
    end else begin
      pend_q <= (rd_data ? '0 : pend_q) | chg;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      irq_q <= '0;
    end else begin
      irq_q <= |(stat_q & mask_q);
    end
  end

  assign irq = irq_q;

  //////////////////////////////////////////////////////////////////////////////
  // Remote wakeup.

  logic wake_src;
  logic wake_src_q;
  logic wake_rise;
  logic wake_out_q;
  logic cap_q;

  // A select beyond the pin count reads low and can never raise a wakeup.
  assign wake_src = wake_q.hw_en ?
    ((int'(wake_q.sel) < NPINS) ? pin_q[wake_q.sel] : 1'b0) : sw_wake_q;
  assign wake_rise = wake_src && !wake_src_q;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wake_src_q <= '0;
    end else begin
      wake_src_q <= wake_src;
    end
  end

  // Edges outside suspend are dropped, not saved for later.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wake_out_q <= '0;
    end else begin
      wake_out_q <= wake_rise && usb_suspended && host_wake_en;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cap_q <= '0;
    end else begin
      cap_q <= WAKE_CAPABLE;
    end
  end

  assign remote_wake = wake_out_q;
  assign wake_capable = cap_q;

  //////////////////////////////////////////////////////////////////////////////
  // Read port.

  logic [REG_W-1:0] rdata_q;
  logic [REG_W-1:0] rd_d;

  always_comb begin
    rd_d = '0;
    if (reg_req.rd) begin
      case (reg_req.addr)
        OFF_DATA: rd_d = REG_W'(pin_q);
        OFF_DIR: rd_d = REG_W'(dir_q);
        OFF_MASK: rd_d = REG_W'(mask_q);
        OFF_STAT: rd_d = REG_W'(stat_q);
        OFF_PEND: rd_d = REG_W'(pend_q);
        OFF_WAKE: rd_d = REG_W'(wake_q);
        OFF_SWWAKE: rd_d = REG_W'(sw_wake_q);
        OFF_DEB: rd_d = REG_W'(deb_short_q);
        default: rd_d = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rd_d;
    end
  end

  assign reg_rdata = rdata_q;

  //////////////////////////////////////////////////////////////////////////////
  // Checks.

  property p_dir_to_pad;
    @(posedge clk_sys) disable iff (sys_rst)
      wr_dir |-> ##2 (gpio_oe_n == ~$past(reg_req.wdata[NPINS-1:0], 2));
  endproperty
  a_dir_to_pad: assert property (p_dir_to_pad) else $error("direction write not on pads");

  property p_data_to_pad;
    @(posedge clk_sys) disable iff (sys_rst)
      wr_data |-> ##2 (gpio_out == $past(reg_req.wdata[NPINS-1:0], 2));
  endproperty
  a_data_to_pad: assert property (p_data_to_pad) else $error("data write not on pads");

  property p_chg_sets_stat;
    @(posedge clk_sys) disable iff (sys_rst)
      (|chg) |=> ((stat_q & $past(chg)) == $past(chg)) && ((pend_q & $past(chg)) == $past(chg));
  endproperty
  a_chg_sets_stat: assert property (p_chg_sets_stat) else $error("change lost");

  property p_mask_blocks;
    @(posedge clk_sys) disable iff (sys_rst)
      ((mask_q == '0) [*2]) |-> !irq;
  endproperty
  a_mask_blocks: assert property (p_mask_blocks) else $error("masked interrupt reached line");

  property p_unmasked_irq;
    @(posedge clk_sys) disable iff (sys_rst)
      (|(stat_q & mask_q)) |=> irq;
  endproperty
  a_unmasked_irq: assert property (p_unmasked_irq) else $error("interrupt missing");

  property p_data_read;
    @(posedge clk_sys) disable iff (sys_rst)
      rd_data |=> (reg_rdata == REG_W'($past(pin_q)));
  endproperty
  a_data_read: assert property (p_data_read) else $error("data read not pin state");

  property p_pend_hold;
    @(posedge clk_sys) disable iff (sys_rst)
      !rd_data |=> ((pend_q & $past(pend_q)) == $past(pend_q));
  endproperty
  a_pend_hold: assert property (p_pend_hold) else $error("pending change dropped");

  property p_pend_clear;
    @(posedge clk_sys) disable iff (sys_rst)
      (rd_data && chg == '0) |=> (pend_q == '0);
  endproperty
  a_pend_clear: assert property (p_pend_clear) else $error("pending not cleared by read");

  property p_wake_rise;
    @(posedge clk_sys) disable iff (sys_rst)
      (wake_src && !wake_src_q && usb_suspended && host_wake_en) |=> remote_wake ##1 !remote_wake;
  endproperty
  a_wake_rise: assert property (p_wake_rise) else $error("wakeup edge missed");

  property p_wake_gate;
    @(posedge clk_sys) disable iff (sys_rst)
      remote_wake |-> $past(usb_suspended) && $past(host_wake_en) && $past(wake_src);
  endproperty
  a_wake_gate: assert property (p_wake_gate) else $error("wakeup while not allowed");

  property p_sw_wake;
    @(posedge clk_sys) disable iff (sys_rst)
      (!wake_q.hw_en && !sw_wake_q && wr_sw && reg_req.wdata[SWWAKE_BIT] && !wr_wake)
        ##1 (usb_suspended && host_wake_en) |=> remote_wake;
  endproperty
  a_sw_wake: assert property (p_sw_wake) else $error("software wakeup missed");

  property p_unmapped;
    @(posedge clk_sys) disable iff (sys_rst)
      (reg_req.rd && !(reg_req.addr inside {[OFF_DATA:OFF_DEB]})) |=> (reg_rdata == '0);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

endmodule

/* File: bench/gjdw_far_model.sv */
`timescale 1ns/1ns
module gjdw_far_model (
  input wire logic clk_sys, // System clock.
  input wire logic sys_rst, // Synchronous reset, active high.
  input wire logic [7:0] gpio_out, // Pad values from the block.
  input wire logic [7:0] gpio_oe_n, // Pad enables, low drives.
  input wire logic [7:0] jack_lvl, // Levels the outside world puts on undriven pads.
  input wire logic want_suspend, // Host wishes the link suspended.
  input wire logic want_wake_en, // Host wishes to enable wakeup.
  input wire logic wake_capable, // Capability from the descriptor.
  input wire logic remote_wake, // Wakeup pulse from the block.
  output logic [7:0] gpio_in, // Resolved pad levels.
  output logic usb_suspended, // Link suspend state.
  output logic host_wake_en, // Host has enabled wakeup.
  output logic [7:0] wake_count // Wakeup pulses seen by the host.
);
  //////////////////////////////////////////////////////////////////////////////
  // A pad the block drives shows its value; any other shows the jack level.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      gpio_in[i] = gpio_oe_n[i] ? jack_lvl[i] : gpio_out[i];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // The host only enables wakeup on a device that reports it can wake.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      usb_suspended <= 1'b0;
      host_wake_en <= 1'b0;
      wake_count <= 8'h00;
    end else begin
      usb_suspended <= want_suspend;
      host_wake_en <= want_wake_en & wake_capable;
      if (remote_wake) begin
        wake_count <= wake_count + 8'h01;
      end
    end
  end
endmodule

/* File: bench/tb.sv */
`timescale 1ns/1ns
module tb;
  import gjdw_pkg::*;
  localparam int LONG = 20;
  localparam int SHORT = 10;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  gjdw_bus_t req = '0;
  logic [REG_W-1:0] reg_rdata;
  logic [7:0] gpio_in, gpio_out, gpio_oe_n, wcnt, c, v, dir, dat, ext, m;
  logic [7:0] jack = 8'h00;
  logic usb_suspended, host_wake_en, remote_wake, wake_capable, irq;
  logic want_susp = 1'b0;
  logic want_en = 1'b0;
  logic [2:0] p;
  int mismatches = 0;
  int num_checks = 0;

  always #2 clk_sys = ~clk_sys;

  gjdw_gpio #(.NPINS(8), .DEB_LONG_CYC(LONG), .DEB_SHORT_CYC(SHORT)) dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_req(req), .reg_rdata(reg_rdata),
    .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n),
    .usb_suspended(usb_suspended), .host_wake_en(host_wake_en),
    .remote_wake(remote_wake), .wake_capable(wake_capable), .irq(irq));

  gjdw_far_model far (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n),
    .jack_lvl(jack), .want_suspend(want_susp), .want_wake_en(want_en),
    .wake_capable(wake_capable), .remote_wake(remote_wake), .gpio_in(gpio_in),
    .usb_suspended(usb_suspended), .host_wake_en(host_wake_en), .wake_count(wcnt));

  //////////////////////////////////////////////////////////////////////////////
  // Expectations and checks.
  function automatic logic [7:0] exp_pins(logic [7:0] d, logic [7:0] o, logic [7:0] j);
    return (d & o) | (~d & j);
  endfunction

  task automatic chk_reg(string what, logic [7:0] exp, logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bit(string what, logic exp, logic got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Register bus cycles; reads sample the data in the one cycle it stands.
  task automatic cyc(int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic wr(logic [ADDR_W-1:0] a, logic [7:0] d);
    @(posedge clk_sys);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    req.wr <= 1'b0;
  endtask

  task automatic rd(logic [ADDR_W-1:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    req.rd <= 1'b0;
    // Sample mid-cycle while the data stand, then return on an edge for the next drive.
    @(negedge clk_sys);
    d = reg_rdata;
    @(posedge clk_sys);
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    summarize();
  end

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(19644));
    cyc(6);
    sys_rst <= 1'b0;
    cyc(1);
    #1;
    chk_reg("oe_n", 8'hff, gpio_oe_n);
    chk_bit("irq", 1'b0, irq);
    chk_bit("wake_capable", 1'b1, wake_capable);
    rd(OFF_DIR, v);
    chk_reg("dir", RST_DIR, v);
    rd(OFF_WAKE, v);
    chk_reg("wake", {4'h0, RST_WAKE}, v);
    wr(16'h0308, 8'hff);
    rd(16'h0308, v);
    chk_reg("unmapped", 8'h00, v);
    // Random direction, output and jack patterns, read back through the pads.
    for (int i = 0; i < 4; i++) begin
      dir = 8'($urandom);
      dat = 8'($urandom);
      ext = 8'($urandom);
      jack <= ext;
      wr(OFF_DIR, dir);
      wr(OFF_DATA, dat);
      cyc(3);
      chk_reg("gpio_out", dat, gpio_out);
      chk_reg("gpio_oe_n", ~dir, gpio_oe_n);
      rd(OFF_DATA, v);
      chk_reg("pins", exp_pins(dir, dat, ext), v);
    end
    // Settle everything to quiet inputs, then clear all change history.
    wr(OFF_DIR, 8'h00);
    wr(OFF_MASK, 8'h00);
    jack <= 8'h00;
    cyc(3 * LONG);
    wr(OFF_STAT, 8'hff);
    rd(OFF_DATA, v);
    rd(OFF_PEND, v);
    chk_reg("pend_clear", 8'h00, v);
    // Long then short filter: a glitch is dropped, a real change is timed.
    for (int i = 0; i < 2; i++) begin
      p = 3'($urandom_range(7));
      m = 8'($urandom);
      wr(OFF_DEB, 8'(i));
      wr(OFF_MASK, m);
      rd(OFF_MASK, v);
      chk_reg("mask", m, v);
      jack[p] <= 1'b1;
      cyc(5);
      jack[p] <= 1'b0;
      cyc(LONG + 5);
      rd(OFF_STAT, v);
      chk_reg("glitch", 8'h00, v);
      jack[p] <= 1'b1;
      cyc(SHORT + 5);
      rd(OFF_STAT, v);
      chk_reg("early", (i == 1) ? 8'h01 << p : 8'h00, v);
      cyc(LONG);
      rd(OFF_STAT, v);
      chk_reg("stat", 8'h01 << p, v);
      cyc(1);
      #1;
      chk_bit("irq_mask", m[p], irq);
      wr(OFF_STAT, 8'h01 << p);
      cyc(2);
      #1;
      chk_bit("irq_clr", 1'b0, irq);
      rd(OFF_PEND, v);
      chk_reg("pend_held", 8'h01 << p, v);
      rd(OFF_DATA, v);
      chk_reg("pins_after_irq", 8'h01 << p, v);
      rd(OFF_PEND, v);
      chk_reg("pend_read", 8'h00, v);
      jack[p] <= 1'b0;
      cyc(LONG + 5);
      wr(OFF_STAT, 8'hff);
      rd(OFF_DATA, v);
    end
    // Changes on pins that are outputs never reach the status register.
    wr(OFF_DIR, 8'hff);
    wr(OFF_DATA, 8'hff);
    cyc(LONG + 5);
    wr(OFF_DATA, 8'h00);
    cyc(LONG + 5);
    rd(OFF_STAT, v);
    chk_reg("out_change", 8'h00, v);
    wr(OFF_DIR, 8'h00);
    // Hardware wakeup: only the selected pin, only when suspended and enabled.
    for (int i = 0; i < 3; i++) begin
      p = 3'($urandom_range(7));
      wr(OFF_WAKE, {4'h0, p, 1'b1});
      want_susp <= (i != 1);
      want_en <= (i != 2);
      cyc(3);
      c = wcnt;
      jack[p ^ 3'h1] <= 1'b1;
      cyc(4);
      chk_reg("other_pin", c, wcnt);
      jack[p] <= 1'b1;
      cyc(4);
      chk_reg("hw_wake", c + 8'(i == 0), wcnt);
      jack <= 8'h00;
      cyc(3);
    end
    // Software wakeup: a zero then one write of the wake bit, with and without enable.
    wr(OFF_WAKE, 8'h00);
    want_susp <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      want_en <= (i == 0);
      wr(OFF_SWWAKE, 8'h00);
      cyc(3);
      c = wcnt;
      wr(OFF_SWWAKE, 8'h01 << SWWAKE_BIT);
      cyc(4);
      chk_reg("sw_wake", c + 8'(i == 0), wcnt);
    end
    summarize();
  end
endmodule
